//--- verilog/acr2_pkg.sv
// constants of the second control register block
package acr2_pkg;
   localparam logic [7:0] ACR2_ADDR_CTRL2     = 8'h2b;
   localparam logic [7:0] ACR2_CTRL2_RESET    = 8'h00;
   localparam int         ACR2_BIT_SELF_TEST  = 7;
   localparam int         ACR2_BIT_SW_RESET   = 6;
   localparam int         ACR2_BIT_SPARE      = 5;
   localparam int         ACR2_SLP_OSR_HI     = 4;
   localparam int         ACR2_SLP_OSR_LO     = 3;
   localparam int         ACR2_BIT_AUTO_SLEEP = 2;
   localparam int         ACR2_WAKE_OSR_HI    = 1;
   localparam int         ACR2_WAKE_OSR_LO    = 0;
   localparam int         ACR2_CLK_HZ         = 20000000;
   localparam int         ACR2_BOOT_US        = 1000;
   localparam int         ACR2_BOOT_CYCLES    = (ACR2_CLK_HZ / 1000000) * ACR2_BOOT_US;
   localparam int         ACR2_STOP_CYCLES    = 4;
   typedef enum logic [1:0] {ACR2_OSR_NORMAL, ACR2_OSR_LNLP, ACR2_OSR_HIRES, ACR2_OSR_LOWPWR} acr2_osr_t;
endpackage

//--- verilog/acr2_counter.sv
// down counter used for the standby wait and the boot interval
`timescale 1ns/10ps
`default_nettype none
module acr2_counter
   import acr2_pkg::*;
#(
   parameter int W = 16
)
(
   input  wire logic         i_clk,   // clock
   input  wire logic         i_rst_n, // synchronised reset
   input  wire logic         i_load,  // load pulse
   input  wire logic [W-1:0] i_value, // load value
   output logic              o_zero   // count reached zero
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   always_comb
   begin
      next_cnt = cnt;
      if (i_load)
         next_cnt = i_value;
      else if (cnt != '0)
         next_cnt = cnt - 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign o_zero = (cnt == '0);
endmodule
`default_nettype wire

//--- verilog/acr2_ctrl.sv
// second control register with software and pin reset sequencing
//
// Contract
// [R1] eight-bit register 0x2b, resets zero, read-write
// [R2] bit 7 enables self-test output shift
// [R3] writing bit 6 starts software reset
// [R4] active mode: standby first, then reboot
// [R5] reset also resets serial interface logic
// [R6] host waits 1 ms after reset
// [R7] host keeps bus quiet during reset
// [R8] hardware clears reset bit at boot end
// [R9] reset pin pulse equals software reset; a pin pulse during boot also restarts the boot interval
// [R10] bits 4:3 select sleep oversampling mode
// [R11] mode codes: normal, lnlp, hires, lowpower
// [R12] bit 2 auto-sleep flushes fifo on transitions
// [R13] bits 1:0 select wake oversampling mode
// [R14] bit 5 stored, no effect
`timescale 1ns/10ps
`default_nettype none
module acr2_ctrl
   import acr2_pkg::*;
(
   input  wire logic       i_clk,           // 20 MHz clock
   input  wire logic       i_arst_n,        // async reset, active low
   input  wire logic       i_reset_pin,     // external reset pin, active high
   input  wire logic       i_wr,            // register write strobe
   input  wire logic       i_rd,            // register read strobe
   input  wire logic [7:0] i_addr,          // register address
   input  wire logic [7:0] i_wdata,         // write data
   input  wire logic       i_active,        // device active mode
   input  wire logic       i_sleep,         // system in sleep mode
   output logic [7:0]      o_rdata,         // read data
   output logic            o_hit,           // address matches this register
   output logic            o_self_test,     // self-test enable
   output acr2_osr_t       o_sleep_osr,     // sleep oversampling mode
   output acr2_osr_t       o_wake_osr,      // wake oversampling mode
   output logic            o_auto_sleep,    // auto-sleep enable
   output logic            o_force_standby, // request leave of active mode
   output logic            o_booting,       // standby wait or reboot in progress
   output logic            o_block_reset,   // reset of functional blocks and defaults
   output logic            o_serial_reset,  // reset of serial interface logic
   output logic            o_fifo_flush,    // fifo flush pulse
   output logic            o_counter_reset  // block counter reset pulse
);
   // ===========================================
   // reset synchroniser
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ===========================================
   // reset sequencer
   typedef enum logic [1:0] {ACR2_IDLE, ACR2_STOP, ACR2_BOOT} acr2_state_t;
   acr2_state_t state;
   acr2_state_t next_state;
   logic        pin_q;
   logic        next_pin_q;
   logic        sw_req;
   logic        pin_req;
   logic        load_stop;
   logic        load_boot;
   logic        cnt_zero;
   logic [15:0] cnt_value;

   assign sw_req  = i_wr && i_addr == ACR2_ADDR_CTRL2 && i_wdata[ACR2_BIT_SW_RESET]
                    && state == ACR2_IDLE;                                  // see [R3]
   assign pin_req = i_reset_pin && !pin_q;                                  // see [R9]
   // pin edge during boot restarts the full boot interval, never the short stop wait
   assign load_stop = (sw_req || pin_req) && i_active && state == ACR2_IDLE;
   assign load_boot = ((sw_req || pin_req) && !i_active && state == ACR2_IDLE)
                      || (pin_req && state == ACR2_BOOT) || (state == ACR2_STOP && cnt_zero);
   assign cnt_value = load_stop ? 16'(ACR2_STOP_CYCLES) : 16'(ACR2_BOOT_CYCLES);

   acr2_counter #(.W(16)) u_cnt
   (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_load  (load_stop || load_boot),
      .i_value (cnt_value),
      .o_zero  (cnt_zero)
   );

   always_comb
   begin
      next_pin_q = i_reset_pin;
      next_state = state;
      case (state)
         ACR2_IDLE:
            if (load_stop)
               next_state = ACR2_STOP;                                      // see [R4]
            else if (load_boot)
               next_state = ACR2_BOOT;                                      // see [R4]
         ACR2_STOP:
            if (cnt_zero)
               next_state = ACR2_BOOT;
         ACR2_BOOT:
            if (cnt_zero && !load_boot)
               next_state = ACR2_IDLE;
         default:
            next_state = ACR2_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ACR2_IDLE;
         pin_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pin_q <= next_pin_q;
      end
   end

   // ===========================================
   // register
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic       sleep_q;
   logic       next_sleep_q;
   logic       boot_done;

   assign boot_done = state == ACR2_BOOT && next_state == ACR2_IDLE;

   always_comb
   begin
      next_ctrl    = ctrl;
      next_sleep_q = i_sleep;
      if (state == ACR2_BOOT)
         next_ctrl = ACR2_CTRL2_RESET | (8'h01 << ACR2_BIT_SW_RESET);       // see [R3]
      if (boot_done)
         next_ctrl = ACR2_CTRL2_RESET;                                      // see [R8]
      else if (i_wr && i_addr == ACR2_ADDR_CTRL2 && state == ACR2_IDLE && !pin_req)
         next_ctrl = i_wdata;                                               // see [R1] [R14]
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl    <= ACR2_CTRL2_RESET;                                       // see [R1]
         sleep_q <= 1'b0;
         o_rdata <= 8'h00;
      end
      else
      begin
         ctrl    <= next_ctrl;
         sleep_q <= next_sleep_q;
         o_rdata <= (i_rd && o_hit) ? ctrl : 8'h00;
      end
   end

   assign o_hit           = i_addr == ACR2_ADDR_CTRL2;
   assign o_self_test     = ctrl[ACR2_BIT_SELF_TEST];                       // see [R2]
   assign o_sleep_osr     = acr2_osr_t'(ctrl[ACR2_SLP_OSR_HI:ACR2_SLP_OSR_LO]);  // see [R10] [R11]
   assign o_wake_osr      = acr2_osr_t'(ctrl[ACR2_WAKE_OSR_HI:ACR2_WAKE_OSR_LO]); // see [R13] [R11]
   assign o_auto_sleep    = ctrl[ACR2_BIT_AUTO_SLEEP];
   assign o_force_standby = state == ACR2_STOP;                             // see [R4]
   assign o_booting       = state != ACR2_IDLE;
   assign o_block_reset   = state == ACR2_BOOT;                             // see [R3]
   assign o_serial_reset  = !rst_n || state == ACR2_BOOT;                   // see [R5] [R9]
   assign o_fifo_flush    = o_auto_sleep && (sleep_q != i_sleep) && state == ACR2_IDLE; // see [R12]
   assign o_counter_reset = o_fifo_flush;                                   // see [R12]

   // ===========================================
   // checks
   sequence s_boot_end;
      state == ACR2_BOOT && cnt_zero && !pin_req;
   endsequence

   sequence s_reg_write;
      i_wr && o_hit && state == ACR2_IDLE && !pin_req;
   endsequence

   a_boot_clears_rst: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R8]
      s_boot_end |=> !ctrl[ACR2_BIT_SW_RESET] && state == ACR2_IDLE)
      else $error("reset bit not cleared at boot end");
   a_standby_first: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R4]
      (state == ACR2_IDLE && sw_req && i_active) |=> state == ACR2_STOP ##[1:8] state == ACR2_BOOT)
      else $error("active reset did not pass standby");
   a_standby_boot_now: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R4]
      (state == ACR2_IDLE && sw_req && !i_active) |=> state == ACR2_BOOT)
      else $error("standby reset did not boot at once");
   a_pin_reset: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R9]
      (state == ACR2_IDLE && pin_req) |=> o_booting)
      else $error("pin pulse ignored");
   a_serial_reset: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R5]
      o_block_reset |-> o_serial_reset)
      else $error("serial logic not reset");
   a_write_stores: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R1]
      (i_wr && o_hit && state == ACR2_IDLE && !pin_req && !i_wdata[ACR2_BIT_SW_RESET])
      |=> ctrl == $past(i_wdata))
      else $error("write not stored");
   a_self_test_out: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R2]
      o_block_reset |=> !o_self_test && o_wake_osr == ACR2_OSR_NORMAL)
      else $error("self-test not cleared by reboot");
   a_flush_gated: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R12]
      o_fifo_flush |-> ctrl[2] && $changed(i_sleep))
      else $error("flush without auto-sleep transition");
   a_read_data: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R1]
      (i_rd && o_hit) |=> o_rdata == $past(ctrl))
      else $error("read data differs from register");
   a_read_zero: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R1]
      !(i_rd && o_hit) |=> o_rdata == 8'h00)
      else $error("read data not zero without a hit");
   a_sleep_osr: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R10]
      s_reg_write |=> o_sleep_osr == acr2_osr_t'($past(i_wdata[ACR2_SLP_OSR_HI:ACR2_SLP_OSR_LO])))
      else $error("sleep oversampling field not taken");
   a_wake_osr: assert property (@(posedge i_clk) disable iff (!rst_n) // see [R13]
      s_reg_write |=> o_wake_osr == acr2_osr_t'($past(i_wdata[ACR2_WAKE_OSR_HI:ACR2_WAKE_OSR_LO])))
      else $error("wake oversampling field not taken");
endmodule
`default_nettype wire

//--- sim/acr2_host.sv
// host model driving the register port and the reset pin
`timescale 1ns/10ps
`default_nettype none
module acr2_host
   import acr2_pkg::*;
(
   input  wire logic       i_clk,      // clock
   input  wire logic [7:0] i_rdata,    // read data
   output logic            o_wr,       // write strobe
   output logic            o_rd,       // read strobe
   output logic [7:0]      o_addr,     // address
   output logic [7:0]      o_wdata,    // write data
   output logic            o_reset_pin // reset pin drive
);
   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_reset_pin = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask
   task automatic pin();
      @(posedge i_clk);
      o_reset_pin <= 1'b1;
      @(posedge i_clk);
      o_reset_pin <= 1'b0;
   endtask
   // no strobes for most of the boot interval
   task automatic quiet();
      repeat (ACR2_BOOT_CYCLES - 2) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

//--- sim/tb_accel_control_two_register.sv
// self-checking bench for the second control register
`timescale 1ns/10ps
`default_nettype none
module tb_accel_control_two_register
   import acr2_pkg::*;
;
   logic       i_clk, i_arst_n, i_active, i_sleep, wr, rd, pin, hit, ste, asl, fs, bt, br, sr, ff, cr;
   logic [7:0] addr, wdata, rdata, d;
   acr2_osr_t  sosr, wosr;
   int         fails, comparisons;
   acr2_ctrl dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reset_pin(pin), .i_wr(wr), .i_rd(rd),
      .i_addr(addr), .i_wdata(wdata), .i_active(i_active), .i_sleep(i_sleep), .o_rdata(rdata),
      .o_hit(hit), .o_self_test(ste), .o_sleep_osr(sosr), .o_wake_osr(wosr), .o_auto_sleep(asl),
      .o_force_standby(fs), .o_booting(bt), .o_block_reset(br), .o_serial_reset(sr),
      .o_fifo_flush(ff), .o_counter_reset(cr));
   acr2_host host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata), .o_reset_pin(pin));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_regs();
      logic [7:0] v;
      host.rd(8'h2a, d);
      chk(d, 8'h00);
      chk({7'h00, hit}, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         v = {c[1], 1'b0, c[0], c[1:0], c[0], ~c[1:0]};
         host.wr(ACR2_ADDR_CTRL2, v);
         host.rd(ACR2_ADDR_CTRL2, d);
         chk(d, v);
         chk({1'b0, hit, ste, sosr, asl, wosr}, {2'b01, v[7], v[4:0]});
      end
   endtask
   task automatic t_sleep(input logic en);
      int n;
      n = 0;
      host.wr(ACR2_ADDR_CTRL2, {5'h00, en, 2'b00});
      repeat (2)
      begin
         @(posedge i_clk);
         i_sleep <= ~i_sleep;
         repeat (4)
         begin
            #1 n += int'({ff, cr});
            @(posedge i_clk);
         end
      end
      chk(8'(n), {5'h00, en, en, 1'b0});
   endtask
   task automatic t_boot(input logic act, input logic use_pin);
      int k;
      host.wr(ACR2_ADDR_CTRL2, 8'h9f);
      i_active <= act;
      if (use_pin)
         host.pin();
      else
         host.wr(ACR2_ADDR_CTRL2, 8'h40);
      #1 chk({5'h00, bt, sr, fs}, {5'h00, 1'b1, ~act, act});
      k = 0;
      while (br !== 1'b1 && k < 10)
      begin
         @(posedge i_clk);
         #1 k++;
      end
      chk({5'h00, k == 10, k != 0, fs}, {5'h00, 1'b0, act, 1'b0});
      host.quiet();
      #1 chk({7'h00, bt}, 8'h01);
      repeat (3) @(posedge i_clk);
      #1 chk({6'h00, bt, br}, 8'h00);
      @(posedge i_clk);
      i_active <= 1'b0;
      host.rd(ACR2_ADDR_CTRL2, d);
      chk(d, ACR2_CTRL2_RESET);
   endtask
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial
   begin
      repeat (4 * ACR2_BOOT_CYCLES) @(posedge i_clk);
      fails++;
      end_of_test();
   end
   initial
   begin
      fails = 0;
      comparisons = 0;
      i_arst_n = 1'b0;
      i_active = 1'b0;
      i_sleep = 1'b0;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_regs();
      t_sleep(1'b0);
      t_sleep(1'b1);
      t_boot(1'b0, 1'b0);
      t_boot(1'b1, 1'b0);
      t_boot(1'b0, 1'b1);
      end_of_test();
   end
endmodule
`default_nettype wire
